// >>> common/alias_cfg_pkg.sv
// Package with offsets, field layouts and reset values of the alias/config bank
package alias_cfg_pkg;
    // Register offsets on the serial control bus
    localparam logic [7:0] ADDR_TARGET4_ALIAS = 8'h7a;
    localparam logic [7:0] ADDR_TARGET5_ALIAS = 8'h7b;
    localparam logic [7:0] ADDR_TARGET6_ALIAS = 8'h7c;
    localparam logic [7:0] ADDR_TARGET7_ALIAS = 8'h7d;
    localparam logic [7:0] ADDR_LINK_SEC_CFG = 8'hc2;

    // Alias table shape
    localparam int ALIAS_COUNT = 4;
    localparam int ADDR7_W = 7;
    localparam int ALIAS_LSB = 1;
    localparam logic [6:0] ALIAS_RESET = 7'h00;

    // Configuration field positions
    localparam int CFG_ENH_BIT = 7;
    localparam int CFG_RPT_BIT = 5;
    localparam int CFG_MODE_LSB = 3;
    localparam int CFG_QUAL_BIT = 1;
    localparam logic [7:0] CFG_RESET = 8'h80;

    // Encryption control modes
    localparam logic [1:0] ENC_AUTHENTICATED = 2'h0;
    localparam logic [1:0] ENC_REG_CONTROL = 2'h1;
    localparam logic [1:0] ENC_ALWAYS = 2'h2;
    localparam logic [1:0] ENC_PER_FRAME_INBAND = 2'h3;

    // Verification happens on every sixteenth frame
    localparam logic [3:0] VERIFY_LAST_FRAME = 4'hf;
endpackage

// >>> src/alias_match.sv
// Alias compare and remap for the four remote targets of one link port
`timescale 1ns/1ps
module alias_match
    import alias_cfg_pkg::*;
(
    input wire logic [ADDR7_W-1:0] addr_i,
    input wire logic [ALIAS_COUNT*ADDR7_W-1:0] aliases_i,
    input wire logic [ALIAS_COUNT*ADDR7_W-1:0] target_ids_i,
    output logic hit_o,
    output logic [ADDR7_W-1:0] remap_o
);
    // Lowest matching target wins; a zero alias never matches
    always_comb begin
        logic [ADDR7_W-1:0] al;
        al = '0;
        hit_o = 1'b0;
        remap_o = '0;
        for (int i = ALIAS_COUNT - 1; i >= 0; i--) begin
            al = aliases_i[i*ADDR7_W +: ADDR7_W];
            if ((al != '0) && (al == addr_i)) begin
                hit_o = 1'b1;
                remap_o = target_ids_i[i*ADDR7_W +: ADDR7_W];
            end
        end
    end
endmodule // alias_match

// >>> src/remote_alias_and_link_cfg_regs.sv
// Remote-target alias registers and link security configuration register
//
// Functional notes
// - Four 7-bit alias registers, bit 0 reserved
// - Matching alias remaps to stored target address
// - Zero alias disables that remote target
// - Second port select redirects alias register access
// - Forward remapped 7-bit address over back channel
// - Enhanced verification checks every sixteenth frame
// - Config resets to 0x80, verification enabled
// - Bit 5 enables repeater mode
// - Bits 4:3 select encryption control mode
// - Repeater strap loads mode 11, else 00
// - Qualify 0: detect alone raises interrupt
// - Qualify 1: detect needs receive lock too
// - Interrupt passes only while its enable set
`timescale 1ns/1ps
module remote_alias_and_link_cfg_regs
    import alias_cfg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Register access from the serial control bus slave
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Loose control bits held elsewhere in the register file
    input wire logic second_port_select_i,
    input wire logic receiver_detect_irq_enable_i,
    input wire logic [ALIAS_COUNT*ADDR7_W-1:0] target_ids_p0_i,
    input wire logic [ALIAS_COUNT*ADDR7_W-1:0] target_ids_p1_i,
    // Incoming remote transactions
    input wire logic txn_valid_i,
    input wire logic [ADDR7_W-1:0] txn_addr_i,
    input wire logic txn_port_i,
    output logic fwd_valid_o,
    output logic [ADDR7_W-1:0] fwd_addr_o,
    output logic fwd_port_o,
    output logic txn_reject_o,
    // Video and encryption side
    input wire logic frame_start_i,
    input wire logic authenticated_i,
    input wire logic reg_encrypt_i,
    input wire logic inband_encrypt_i,
    output logic verify_check_o,
    output logic encrypt_frame_o,
    output logic enhanced_verify_enable_o,
    output logic transmitter_repeater_enable_o,
    output logic [1:0] enc_mode_o,
    // Pins
    input wire logic repeater_strap_i,
    input wire logic rx_detect_i,
    input wire logic rx_lock_i,
    output logic receiver_detect_irq_o
);
    // Alias index decode, used for both read and write
    function automatic logic [2:0] alias_slot(input logic [7:0] a);
        case (a)
            ADDR_TARGET4_ALIAS: alias_slot = 3'h4;
            ADDR_TARGET5_ALIAS: alias_slot = 3'h5;
            ADDR_TARGET6_ALIAS: alias_slot = 3'h6;
            ADDR_TARGET7_ALIAS: alias_slot = 3'h7;
            default: alias_slot = 3'h0;
        endcase
    endfunction

    logic [ADDR7_W-1:0] alias_p0_reg [0:ALIAS_COUNT-1];
    logic [ADDR7_W-1:0] alias_p1_reg [0:ALIAS_COUNT-1];
    logic enh_reg;
    logic rpt_reg;
    logic [1:0] mode_reg;
    logic qual_reg;
    logic strap_pend_reg;
    logic [1:0] strap_sync_reg;
    logic [1:0] det_sync_reg;
    logic [1:0] lock_sync_reg;
    logic [3:0] frame_cnt_reg;

    // Address decode
    wire logic [2:0] slot = alias_slot(reg_addr_i);
    wire logic alias_sel = slot[2];
    wire logic [1:0] idx = slot[1:0];
    wire logic cfg_sel = (reg_addr_i == ADDR_LINK_SEC_CFG);
    wire logic alias_wr = reg_wr_i && alias_sel;
    wire logic cfg_wr = reg_wr_i && cfg_sel;

    // Read data; alias bit 0 and cfg bits 6, 2, 0 read as zero
    wire logic [ADDR7_W-1:0] alias_rd = second_port_select_i ?
        alias_p1_reg[idx] : alias_p0_reg[idx];
    wire logic [7:0] cfg_rd = {enh_reg, 1'b0, rpt_reg, mode_reg,
        1'b0, qual_reg, 1'b0};
    wire logic [7:0] rd_mux = alias_sel ? {alias_rd, 1'b0} :
        (cfg_sel ? cfg_rd : 8'h00);

    // Flatten the alias tables for the matcher
    logic [ALIAS_COUNT*ADDR7_W-1:0] flat_p0;
    logic [ALIAS_COUNT*ADDR7_W-1:0] flat_p1;
    always_comb begin
        for (int i = 0; i < ALIAS_COUNT; i++) begin
            flat_p0[i*ADDR7_W +: ADDR7_W] = alias_p0_reg[i];
            flat_p1[i*ADDR7_W +: ADDR7_W] = alias_p1_reg[i];
        end
    end

    // Each transaction is matched against its own port's table
    wire logic [ALIAS_COUNT*ADDR7_W-1:0] sel_aliases =
        txn_port_i ? flat_p1 : flat_p0;
    wire logic [ALIAS_COUNT*ADDR7_W-1:0] sel_ids =
        txn_port_i ? target_ids_p1_i : target_ids_p0_i;
    logic hit;
    logic [ADDR7_W-1:0] remap;

    alias_match u_match (
        .addr_i(txn_addr_i),
        .aliases_i(sel_aliases),
        .target_ids_i(sel_ids),
        .hit_o(hit),
        .remap_o(remap)
    );

    // Detect qualification uses only second-stage synchroniser outputs
    wire logic det_s = det_sync_reg[1];
    wire logic lock_s = lock_sync_reg[1];
    wire logic det_qualified = qual_reg ? (det_s && lock_s) : det_s;

    // Encryption decision per mode
    logic enc_next;
    always_comb begin
        case (mode_reg)
            ENC_AUTHENTICATED: enc_next = authenticated_i;
            ENC_REG_CONTROL: enc_next = reg_encrypt_i;
            ENC_ALWAYS: enc_next = 1'b1;
            ENC_PER_FRAME_INBAND: enc_next = inband_encrypt_i;
            default: enc_next = 1'b0;
        endcase
    end

    // Pin synchronisers; they run through reset so the strap is settled
    always_ff @(posedge clk_sys_i) begin
        strap_sync_reg <= {strap_sync_reg[0], repeater_strap_i};
        det_sync_reg <= {det_sync_reg[0], rx_detect_i};
        lock_sync_reg <= {lock_sync_reg[0], rx_lock_i};
    end

    // Alias tables: writes land in the copy picked by the port select
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            for (int i = 0; i < ALIAS_COUNT; i++) begin
                alias_p0_reg[i] <= ALIAS_RESET;
                alias_p1_reg[i] <= ALIAS_RESET;
            end
        end else if (alias_wr) begin
            if (second_port_select_i) begin
                alias_p1_reg[idx] <= reg_wdata_i[7:ALIAS_LSB];
            end else begin
                alias_p0_reg[idx] <= reg_wdata_i[7:ALIAS_LSB];
            end
        end
    end

    // Configuration register; the strap is taken one cycle after release
    // because a sync reset cannot load a pin value directly
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            enh_reg <= CFG_RESET[CFG_ENH_BIT];
            rpt_reg <= CFG_RESET[CFG_RPT_BIT];
            mode_reg <= CFG_RESET[CFG_MODE_LSB +: 2];
            qual_reg <= CFG_RESET[CFG_QUAL_BIT];
            strap_pend_reg <= 1'b1;
        end else begin
            strap_pend_reg <= 1'b0;
            if (cfg_wr) begin
                enh_reg <= reg_wdata_i[CFG_ENH_BIT];
                rpt_reg <= reg_wdata_i[CFG_RPT_BIT];
                mode_reg <= reg_wdata_i[CFG_MODE_LSB +: 2];
                qual_reg <= reg_wdata_i[CFG_QUAL_BIT];
            end else if (strap_pend_reg) begin
                mode_reg <= strap_sync_reg[1] ? ENC_PER_FRAME_INBAND :
                    ENC_AUTHENTICATED;
            end
        end
    end

    // Read port; data holds until the next read
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // Forwarding to the back channel, one cycle after the request
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fwd_valid_o <= 1'b0;
            fwd_addr_o <= '0;
            fwd_port_o <= 1'b0;
            txn_reject_o <= 1'b0;
        end else begin
            fwd_valid_o <= txn_valid_i && hit;
            txn_reject_o <= txn_valid_i && !hit;
            if (txn_valid_i && hit) begin
                fwd_addr_o <= remap;
                fwd_port_o <= txn_port_i;
            end
        end
    end

    // Frame counter for periodic verification
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            frame_cnt_reg <= 4'h0;
            verify_check_o <= 1'b0;
        end else begin
            verify_check_o <= frame_start_i && enh_reg &&
                (frame_cnt_reg == VERIFY_LAST_FRAME);
            if (frame_start_i) begin
                frame_cnt_reg <= frame_cnt_reg + 4'h1;
            end
        end
    end

    // Mode outputs and receiver detect interrupt
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            encrypt_frame_o <= 1'b0;
            enhanced_verify_enable_o <= CFG_RESET[CFG_ENH_BIT];
            transmitter_repeater_enable_o <= CFG_RESET[CFG_RPT_BIT];
            enc_mode_o <= CFG_RESET[CFG_MODE_LSB +: 2];
            receiver_detect_irq_o <= 1'b0;
        end else begin
            encrypt_frame_o <= enc_next;
            enhanced_verify_enable_o <= enh_reg;
            transmitter_repeater_enable_o <= rpt_reg;
            enc_mode_o <= mode_reg;
            receiver_detect_irq_o <= receiver_detect_irq_enable_i &&
                det_qualified;
        end
    end
endmodule // remote_alias_and_link_cfg_regs

// >>> bench/alias_cfg_chk.sv
// Port timing checker for the alias and link config bank
`timescale 1ns/1ps
module alias_cfg_chk
    import alias_cfg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic reg_rd_i,
    input wire logic reg_rvalid_o,
    input wire logic txn_valid_i,
    input wire logic fwd_valid_o,
    input wire logic txn_reject_o,
    input wire logic verify_check_o,
    input wire logic enhanced_verify_enable_o,
    input wire logic [1:0] enc_mode_o,
    input wire logic encrypt_frame_o,
    input wire logic rx_detect_i,
    input wire logic receiver_detect_irq_enable_i,
    input wire logic receiver_detect_irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // Three quiet cycles flush both synchroniser stages
    sequence det_quiet_s;
        !rx_detect_i [*3];
    endsequence
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    txn_answer_a: assert property (
        txn_valid_i |=> fwd_valid_o ^ txn_reject_o)
        else $error("request answer wrong");
    txn_idle_a: assert property (
        !txn_valid_i |=> !fwd_valid_o && !txn_reject_o)
        else $error("answer without request");
    // Pulse and enable copy leave the same flop stage, so compare same cycle
    verify_gate_a: assert property (
        verify_check_o |-> enhanced_verify_enable_o)
        else $error("verify pulse while disabled");
    verify_pulse_a: assert property (verify_check_o |=> !verify_check_o)
        else $error("verify pulse too long");
    verify_reset_a: assert property (
        $fell(srst_i) |-> enhanced_verify_enable_o)
        else $error("verify not on after reset");
    mode_always_a: assert property (
        (enc_mode_o == ENC_ALWAYS) [*2] |-> encrypt_frame_o)
        else $error("always mode not encrypting");
    irq_gate_a: assert property (
        !receiver_detect_irq_enable_i |=> !receiver_detect_irq_o)
        else $error("irq passed while disabled");
    irq_cause_a: assert property (det_quiet_s |=> !receiver_detect_irq_o)
        else $error("irq without detect");
endmodule // alias_cfg_chk
bind remote_alias_and_link_cfg_regs alias_cfg_chk i_chk (.clk_sys_i, .srst_i,
    .reg_rd_i, .reg_rvalid_o, .txn_valid_i, .fwd_valid_o, .txn_reject_o,
    .verify_check_o, .enhanced_verify_enable_o, .enc_mode_o, .encrypt_frame_o,
    .rx_detect_i, .receiver_detect_irq_enable_i, .receiver_detect_irq_o);

// >>> bench/remote_rx_model.sv
// Remote receiver model: presence, lock and a count of forwarded requests
`timescale 1ns/1ps
module remote_rx_model (
    input wire logic clk_sys_i,
    input wire logic present_i,
    input wire logic lock_req_i,
    input wire logic fwd_valid_i,
    output logic rx_detect_o,
    output logic rx_lock_o,
    output int hits_o
);
    // A receiver can only report lock once it is attached
    assign rx_detect_o = present_i;
    assign rx_lock_o = present_i & lock_req_i;
    // Count remapped requests that cross the back channel
    initial hits_o = 0;
    always @(posedge clk_sys_i) begin
        if (fwd_valid_i === 1'b1) begin
            hits_o <= hits_o + 1;
        end
    end
endmodule // remote_rx_model

// >>> bench/testbench.sv
// Self-checking bench for the alias and link config bank
`timescale 1ns/1ps
module testbench
    import alias_cfg_pkg::*;
;
    logic clk, srst, rd, wr, sel, irq_en, tv, tport, fs, auth, renc, ienc;
    logic strap, present, lockr, rvalid, fv, fport, rej, vchk, encf, enh;
    logic rpt, irq, det, lck;
    logic [7:0] addr, wdata, rdata;
    logic [6:0] taddr, faddr;
    logic [1:0] mode;
    logic [27:0] ids0, ids1;
    int al[2][4];
    int n_errors, cmp_count, cyc, seed, hits, hexp, nver, i, k, p, x, e, pt, a;
    remote_alias_and_link_cfg_regs i_dut (.clk_sys_i(clk), .srst_i(srst),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .second_port_select_i(sel), .receiver_detect_irq_enable_i(irq_en),
        .target_ids_p0_i(ids0), .target_ids_p1_i(ids1), .txn_valid_i(tv),
        .txn_addr_i(taddr), .txn_port_i(tport), .fwd_valid_o(fv),
        .fwd_addr_o(faddr), .fwd_port_o(fport), .txn_reject_o(rej),
        .frame_start_i(fs), .authenticated_i(auth), .reg_encrypt_i(renc),
        .inband_encrypt_i(ienc), .verify_check_o(vchk), .encrypt_frame_o(encf),
        .enhanced_verify_enable_o(enh), .transmitter_repeater_enable_o(rpt),
        .enc_mode_o(mode), .repeater_strap_i(strap), .rx_detect_i(det),
        .rx_lock_i(lck), .receiver_detect_irq_o(irq));
    remote_rx_model i_rx (.clk_sys_i(clk), .present_i(present),
        .lock_req_i(lockr), .fwd_valid_i(fv), .rx_detect_o(det),
        .rx_lock_o(lck), .hits_o(hits));
    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rvalid, 1);
        chk(rdata, exp);
    endtask
    // Lowest enabled alias index that matches, or -1
    function automatic int hit(int q, int ad);
        for (int j = 0; j < 4; j++) begin
            if (al[q][j] != 0 && al[q][j] == ad) return j;
        end
        return -1;
    endfunction
    task summarize;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (vchk === 1'b1) nver++;
        if (cyc == 20000) begin
            n_errors++;
            summarize;
        end
    end
    initial begin
        {srst, rd, wr, sel, irq_en, tv, tport, fs} = '0;
        {auth, renc, ienc, present, lockr, strap} = '0;
        addr = 8'h00;
        wdata = 8'h00;
        taddr = 7'h00;
        seed = 63934;
        ids0 = 28'($random(seed));
        ids1 = 28'($random(seed));
        // Reset with each strap level; strap is settled before release
        for (p = 0; p < 2; p++) begin
            srst <= 1'b1;
            strap <= p[0];
            repeat (8) @(posedge clk);
            srst <= 1'b0;
            repeat (3) @(posedge clk);
            rreg(ADDR_LINK_SEC_CFG, p ? 8'h98 : 8'h80);
        end
        wreg(8'h7e, 8'hff);
        rreg(8'h7e, 8'h00);
        // Each port gets its own copy; bit 0 and a zero alias are included
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 4; i++) begin
                x = (p == 0 && i == 3) ? 1 : ($random(seed) & 8'hff);
                if (p == 1 && i == 2) x = al[1][1] << 1;
                al[p][i] = x >> 1;
                sel <= p[0];
                rreg(ADDR_TARGET4_ALIAS + i, 8'h00);
                wreg(ADDR_TARGET4_ALIAS + i, x[7:0]);
            end
        end
        for (i = 0; i < 8; i++) begin
            sel <= i[2];
            rreg(ADDR_TARGET4_ALIAS + i % 4, al[i / 4][i % 4] << 1);
        end
        // Back-to-back requests, each answer checked the next cycle
        for (k = 0; k <= 48; k++) begin
            @(posedge clk);
            pt = $random(seed) & 1;
            a = (k % 3 == 0) ? ($random(seed) & 8'h7f) : al[pt][k % 4];
            tv <= (k < 48);
            tport <= pt[0];
            taddr <= a[6:0];
            @(negedge clk);
            if (k > 0) begin
                chk(fv, e >= 0);
                chk(rej, e < 0);
                if (e >= 0) begin
                    chk(faddr, ((p ? ids1 : ids0) >> (7 * e)) & 7'h7f);
                    chk(fport, p);
                    hexp++;
                end
            end
            e = hit(pt, a);
            p = pt;
        end
        @(negedge clk);
        chk(hits, hexp);
        for (i = 0; i < 4; i++) begin
            x = $random(seed) & 8'hff;
            x[4:3] = i;
            wreg(ADDR_LINK_SEC_CFG, x[7:0]);
            rreg(ADDR_LINK_SEC_CFG, x & 8'hba);
            {auth, renc, ienc} <= 3'($random(seed));
            repeat (2) @(posedge clk);
            #1;
            chk(enh, x[7]);
            chk(rpt, x[5]);
            chk(mode, i);
            chk(encf, i == 0 ? auth : i == 1 ? renc : i == 2 ? 1 : ienc);
        end
        // 32 frames give two checks; with verification off, none
        for (i = 0; i < 2; i++) begin
            wreg(ADDR_LINK_SEC_CFG, i ? 8'h00 : 8'h80);
            repeat (32 - 16 * i) @(posedge clk) fs <= 1'b1;
            @(posedge clk) fs <= 1'b0;
            repeat (3) @(posedge clk);
            chk(nver, 2);
        end
        for (i = 0; i < 16; i++) begin
            wreg(ADDR_LINK_SEC_CFG, i[3] ? 8'h02 : 8'h00);
            irq_en <= i[2];
            present <= i[1];
            lockr <= i[0];
            repeat (5) @(posedge clk);
            #1;
            chk(irq, i[2] & i[1] & (!i[3] | i[0]));
        end
        summarize;
    end
endmodule // testbench
